/* File: rtl/csws_defines.vh */
// Shared constants of the charger two-wire word slave.
`ifndef CSWS_DEFINES_VH
`define CSWS_DEFINES_VH

// Bus address, seven bits, without the direction bit.
`define CSWS_SLAVE_ADDR 7'h09
`define CSWS_DIR_READ 1'h1

// Command codes.
`define CSWS_CMD_CFG 8'h12
`define CSWS_CMD_CUR 8'h14
`define CSWS_CMD_VOLT 8'h15
`define CSWS_CMD_INCUR 8'h3F
`define CSWS_CMD_MAKER 8'hFE
`define CSWS_CMD_PART 8'hFF

// Reset values of the writable words.
`define CSWS_RST_CFG 16'h6000
`define CSWS_RST_ZERO 16'h0000

// Watchdog period field in the configuration word.
`define CSWS_CFG_WD_MSB 14
`define CSWS_CFG_WD_LSB 13
`define CSWS_WD_OFF 2'h0
`define CSWS_WD_P1 2'h1
`define CSWS_WD_P2 2'h2
`define CSWS_WD_P3 2'h3

// Byte framing.
`define CSWS_LAST_BIT 4'h7
`define CSWS_BYTE_BITS 4'h8
`define CSWS_IDX_ADDR 3'h0
`define CSWS_IDX_CMD 3'h1
`define CSWS_IDX_LO 3'h2
`define CSWS_IDX_HI 3'h3

// Times in milliseconds and the clock rate in kHz; counts are derived from them.
`define CSWS_CLK_KHZ 36'h0000061A8
`define CSWS_TIMEOUT_MS 36'h000000019
`define CSWS_DEGLITCH_MS 36'h00000000A
`define CSWS_WD_P1_MS 36'h00000ABE0
`define CSWS_WD_P2_MS 36'h0000157C0
`define CSWS_WD_P3_MS 36'h00002AB98
`define CSWS_CNT_ONE 36'h000000001
`define CSWS_CNT_ZERO 36'h000000000

`endif

/* File: rtl/csws_low_timer.v */
// Clock-low timeout detector of the two-wire bus.
`timescale 1ns/1ps
`include "csws_defines.vh"

module csws_low_timer #(
  parameter [35:0] TIMEOUT_CYC = `CSWS_TIMEOUT_MS * `CSWS_CLK_KHZ
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire scl_i,
  input wire busy_i,
  output wire timeout_o
);

  reg [35:0] cnt_reg;
  reg timeout_reg;

  assign timeout_o = timeout_reg;

  // Counting only while a transfer is open keeps an idle, held-low bus from pulsing forever.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= `CSWS_CNT_ZERO;
      timeout_reg <= 1'b0;
    end else begin
      if (scl_i || !busy_i) begin
        cnt_reg <= `CSWS_CNT_ZERO;
      end else if (cnt_reg != TIMEOUT_CYC) begin
        cnt_reg <= cnt_reg + `CSWS_CNT_ONE;
      end
      timeout_reg <= busy_i && !scl_i && (cnt_reg == TIMEOUT_CYC - `CSWS_CNT_ONE);
    end
  end

endmodule

/* File: rtl/csws_slave.v */
// Charger two-wire word slave: bit engine, command registers and timer hookup.
`timescale 1ns/1ps
`include "csws_defines.vh"

module csws_slave #(
  parameter [35:0] TIMEOUT_CYC = `CSWS_TIMEOUT_MS * `CSWS_CLK_KHZ,
  parameter [35:0] DEGLITCH_CYC = `CSWS_DEGLITCH_MS * `CSWS_CLK_KHZ,
  parameter [35:0] WD_P1_CYC = `CSWS_WD_P1_MS * `CSWS_CLK_KHZ,
  parameter [35:0] WD_P2_CYC = `CSWS_WD_P2_MS * `CSWS_CLK_KHZ,
  parameter [35:0] WD_P3_CYC = `CSWS_WD_P3_MS * `CSWS_CLK_KHZ,
  // Arbitrary identity value.
  parameter [15:0] PART_ID = 16'h0A5A,
  // Arbitrary identity value.
  parameter [15:0] MAKER_ID = 16'h5A0A
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire supply_ok_i,
  input wire adapter_sense_ok_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output wire [15:0] charger_configuration_o,
  output wire [15:0] charge_current_limit_o,
  output wire [15:0] charge_voltage_limit_o,
  output wire [15:0] input_current_limit_o,
  output wire watchdog_expired_o,
  output wire bus_timeout_o
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_TX = 5'h08;
  localparam [4:0] S_MACK = 5'h10;

  reg scl_q;
  reg sda_q;
  reg sda_drv_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [3:0] bit_cnt_reg;
  reg [3:0] bit_cnt_next;
  reg [2:0] byte_idx_reg;
  reg [2:0] byte_idx_next;
  reg [7:0] shift_reg;
  reg [7:0] shift_next;
  reg [7:0] tx_reg;
  reg [7:0] tx_next;
  reg [7:0] cmd_reg;
  reg [7:0] cmd_next;
  reg [7:0] wr_lo_reg;
  reg [7:0] wr_lo_next;
  reg read_reg;
  reg read_next;
  reg have_cmd_reg;
  reg have_cmd_next;
  reg ack_reg;
  reg ack_next;
  reg rx_done_reg;
  reg rx_done_next;
  reg hi_sent_reg;
  reg hi_sent_next;
  reg host_ack_reg;
  reg host_ack_next;
  reg sda_oe_reg;
  reg sda_oe_next;
  reg wr_commit_reg;
  reg wr_commit_next;
  reg [15:0] cfg_reg;
  reg [15:0] cfg_next;
  reg [15:0] cur_reg;
  reg [15:0] cur_next;
  reg [15:0] volt_reg;
  reg [15:0] volt_next;
  reg [15:0] incur_reg;
  reg [15:0] incur_next;
  reg ack_now;

  wire timeout_pulse;
  wire bus_en = supply_ok_i && adapter_sense_ok_i;
  wire scl_rise = scl_i && !scl_q;
  wire scl_fall = !scl_i && scl_q;
  wire start_det = scl_i && scl_q && sda_q && !sda_i;
  wire stop_det = scl_i && scl_q && !sda_q && sda_i;

  // Commands that a word read may address.
  function csws_readable;
    input [7:0] cmd;
    begin
      case (cmd)
        `CSWS_CMD_CFG, `CSWS_CMD_CUR, `CSWS_CMD_VOLT, `CSWS_CMD_INCUR: csws_readable = 1'b1;
        `CSWS_CMD_MAKER, `CSWS_CMD_PART: csws_readable = 1'b1;
        default: csws_readable = 1'b0;
      endcase
    end
  endfunction

  // Commands that a word write may change; identity words are excluded.
  function csws_writable;
    input [7:0] cmd;
    begin
      case (cmd)
        `CSWS_CMD_CFG, `CSWS_CMD_CUR, `CSWS_CMD_VOLT, `CSWS_CMD_INCUR: csws_writable = 1'b1;
        default: csws_writable = 1'b0;
      endcase
    end
  endfunction

  reg [15:0] rd_word;
  always @* begin
    case (cmd_reg)
      `CSWS_CMD_CFG: rd_word = cfg_reg;
      `CSWS_CMD_CUR: rd_word = cur_reg;
      `CSWS_CMD_VOLT: rd_word = volt_reg;
      `CSWS_CMD_INCUR: rd_word = incur_reg;
      `CSWS_CMD_MAKER: rd_word = MAKER_ID;
      `CSWS_CMD_PART: rd_word = PART_ID;
      default: rd_word = `CSWS_RST_ZERO;
    endcase
  end

  // The clock pin is input only: the slave never stretches, so its share of stretch is zero.
  assign sda_o = sda_drv_reg;
  assign sda_oe_o = sda_oe_reg;
  assign charger_configuration_o = cfg_reg;
  assign charge_current_limit_o = cur_reg;
  assign charge_voltage_limit_o = volt_reg;
  assign input_current_limit_o = incur_reg;

  always @* begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    cmd_next = cmd_reg;
    wr_lo_next = wr_lo_reg;
    read_next = read_reg;
    have_cmd_next = have_cmd_reg;
    ack_next = ack_reg;
    rx_done_next = rx_done_reg;
    hi_sent_next = hi_sent_reg;
    host_ack_next = host_ack_reg;
    sda_oe_next = sda_oe_reg;
    wr_commit_next = 1'b0;
    cfg_next = cfg_reg;
    cur_next = cur_reg;
    volt_next = volt_reg;
    incur_next = incur_reg;
    ack_now = 1'b0;
    if (!bus_en) begin
      state_next = S_IDLE;
      sda_oe_next = 1'b0;
      have_cmd_next = 1'b0;
    end else if (timeout_pulse || stop_det) begin
      state_next = S_IDLE;
      sda_oe_next = 1'b0;
      have_cmd_next = 1'b0;
    end else if (start_det) begin
      // A repeated start keeps the command so that a word read can follow.
      state_next = S_RX;
      bit_cnt_next = 4'h0;
      byte_idx_next = `CSWS_IDX_ADDR;
      rx_done_next = 1'b0;
      sda_oe_next = 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          state_next = S_IDLE;
        end
        S_RX: begin
          if (scl_rise && !rx_done_reg) begin
            shift_next = {shift_reg[6:0], sda_i};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `CSWS_LAST_BIT) begin
              rx_done_next = 1'b1;
            end
          end else if (scl_fall && rx_done_reg) begin
            rx_done_next = 1'b0;
            bit_cnt_next = 4'h0;
            state_next = S_ACK;
            case (byte_idx_reg)
              `CSWS_IDX_ADDR: begin
                read_next = shift_reg[0];
                ack_now = (shift_reg[7:1] == `CSWS_SLAVE_ADDR) &&
                  (shift_reg[0] != `CSWS_DIR_READ || have_cmd_reg);
              end
              `CSWS_IDX_CMD: begin
                cmd_next = shift_reg;
                have_cmd_next = csws_readable(shift_reg);
                ack_now = csws_readable(shift_reg);
              end
              `CSWS_IDX_LO: begin
                wr_lo_next = shift_reg;
                ack_now = csws_writable(cmd_reg);
              end
              `CSWS_IDX_HI: begin
                ack_now = csws_writable(cmd_reg);
                if (csws_writable(cmd_reg)) begin
                  wr_commit_next = 1'b1;
                end
                case (cmd_reg)
                  `CSWS_CMD_CFG: cfg_next = {shift_reg, wr_lo_reg};
                  `CSWS_CMD_CUR: cur_next = {shift_reg, wr_lo_reg};
                  `CSWS_CMD_VOLT: volt_next = {shift_reg, wr_lo_reg};
                  `CSWS_CMD_INCUR: incur_next = {shift_reg, wr_lo_reg};
                  default: cfg_next = cfg_reg;
                endcase
              end
              default: begin
                ack_now = 1'b0;
              end
            endcase
            ack_next = ack_now;
            sda_oe_next = ack_now;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_oe_next = 1'b0;
            if (!ack_reg) begin
              state_next = S_IDLE;
            end else if (read_reg) begin
              // The first data bit goes out on the same falling edge that ends the acknowledge.
              tx_next = {rd_word[6:0], 1'b0};
              sda_oe_next = !rd_word[7];
              bit_cnt_next = 4'h1;
              hi_sent_next = 1'b0;
              state_next = S_TX;
            end else begin
              byte_idx_next = byte_idx_reg + 3'h1;
              state_next = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `CSWS_BYTE_BITS) begin
              sda_oe_next = 1'b0;
              host_ack_next = 1'b0;
              state_next = S_MACK;
            end else begin
              sda_oe_next = !tx_reg[7];
              tx_next = {tx_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            host_ack_next = !sda_i;
          end else if (scl_fall) begin
            if (host_ack_reg && !hi_sent_reg) begin
              tx_next = {rd_word[14:8], 1'b0};
              sda_oe_next = !rd_word[15];
              bit_cnt_next = 4'h1;
              hi_sent_next = 1'b1;
              state_next = S_TX;
            end else begin
              state_next = S_IDLE;
            end
          end
        end
        default: begin
          state_next = S_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_drv_reg <= 1'b0;
      state_reg <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= `CSWS_IDX_ADDR;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      cmd_reg <= 8'h00;
      wr_lo_reg <= 8'h00;
      read_reg <= 1'b0;
      have_cmd_reg <= 1'b0;
      ack_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      hi_sent_reg <= 1'b0;
      host_ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_commit_reg <= 1'b0;
      cfg_reg <= `CSWS_RST_CFG;
      cur_reg <= `CSWS_RST_ZERO;
      volt_reg <= `CSWS_RST_ZERO;
      incur_reg <= `CSWS_RST_ZERO;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      sda_drv_reg <= 1'b0;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      cmd_reg <= cmd_next;
      wr_lo_reg <= wr_lo_next;
      read_reg <= read_next;
      have_cmd_reg <= have_cmd_next;
      ack_reg <= ack_next;
      rx_done_reg <= rx_done_next;
      hi_sent_reg <= hi_sent_next;
      host_ack_reg <= host_ack_next;
      sda_oe_reg <= sda_oe_next;
      wr_commit_reg <= wr_commit_next;
      cfg_reg <= cfg_next;
      cur_reg <= cur_next;
      volt_reg <= volt_next;
      incur_reg <= incur_next;
    end
  end

  csws_low_timer #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_low_timer (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .scl_i(scl_i),
    .busy_i(state_reg != S_IDLE),
    .timeout_o(timeout_pulse)
  );

  assign bus_timeout_o = timeout_pulse;

  csws_watchdog #(
    .DEGLITCH_CYC(DEGLITCH_CYC),
    .WD_P1_CYC(WD_P1_CYC),
    .WD_P2_CYC(WD_P2_CYC),
    .WD_P3_CYC(WD_P3_CYC)
  ) u_watchdog (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .restart_i(wr_commit_reg),
    .period_sel_i(cfg_reg[`CSWS_CFG_WD_MSB:`CSWS_CFG_WD_LSB]),
    .expired_o(watchdog_expired_o)
  );

endmodule

/* File: rtl/csws_watchdog.v */
// Host watchdog with a deglitched restart request.
`timescale 1ns/1ps
`include "csws_defines.vh"

module csws_watchdog #(
  parameter [35:0] DEGLITCH_CYC = `CSWS_DEGLITCH_MS * `CSWS_CLK_KHZ,
  parameter [35:0] WD_P1_CYC = `CSWS_WD_P1_MS * `CSWS_CLK_KHZ,
  parameter [35:0] WD_P2_CYC = `CSWS_WD_P2_MS * `CSWS_CLK_KHZ,
  parameter [35:0] WD_P3_CYC = `CSWS_WD_P3_MS * `CSWS_CLK_KHZ
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire restart_i,
  input wire [1:0] period_sel_i,
  output wire expired_o
);

  reg pend_reg;
  reg [35:0] dg_cnt_reg;
  reg [35:0] wd_cnt_reg;
  reg expired_reg;

  function [35:0] csws_period;
    input [1:0] sel;
    begin
      case (sel)
        `CSWS_WD_P1: csws_period = WD_P1_CYC;
        `CSWS_WD_P2: csws_period = WD_P2_CYC;
        default: csws_period = WD_P3_CYC;
      endcase
    end
  endfunction

  wire apply = pend_reg && (dg_cnt_reg >= DEGLITCH_CYC - `CSWS_CNT_ONE);
  wire wd_on = (period_sel_i != `CSWS_WD_OFF);
  wire hit = wd_on && (wd_cnt_reg >= csws_period(period_sel_i) - `CSWS_CNT_ONE);

  assign expired_o = expired_reg;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_reg <= 1'b0;
      dg_cnt_reg <= `CSWS_CNT_ZERO;
      wd_cnt_reg <= `CSWS_CNT_ZERO;
      expired_reg <= 1'b0;
    end else begin
      // A restart request is latched at once and acts only after the whole deglitch time has run.
      if (restart_i) begin
        pend_reg <= 1'b1;
      end else if (apply) begin
        pend_reg <= 1'b0;
      end
      if (!pend_reg || apply) begin
        dg_cnt_reg <= `CSWS_CNT_ZERO;
      end else begin
        dg_cnt_reg <= dg_cnt_reg + `CSWS_CNT_ONE;
      end
      if (apply || !wd_on || hit) begin
        wd_cnt_reg <= `CSWS_CNT_ZERO;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + `CSWS_CNT_ONE;
      end
      // Expiry seen in the same cycle as a restart stays flagged.
      if (hit) begin
        expired_reg <= 1'b1;
      end else if (apply) begin
        expired_reg <= 1'b0;
      end
    end
  end

endmodule

/* File: test/charger_smbus_word_slave_bench.sv */
// Self-checking bench of the charger two-wire word slave driven by a host model.
`timescale 1ns/1ps
`include "csws_defines.vh"
module charger_smbus_word_slave_bench;
  localparam [35:0] WD1 = 36'h00000012C;
  localparam [35:0] WD2 = 36'h000000258;
  localparam [35:0] WD3 = 36'h0000004B0;
  // Identity values are arbitrary.
  localparam [15:0] PID = 16'hC35A;
  localparam [15:0] MID = 16'h3CA5;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, supply_ok = 1'b1, adapter_ok = 1'b1;
  logic scl, host_pull, sda_o, sda_oe, wd_exp, tmo;
  logic [15:0] cfg, cur, volt, incur;
  wire sda = ~host_pull & (~sda_oe | sda_o);
  int n_fail = 0, checks = 0, cyc = 0, n_tmo = 0;
  logic [31:0] seed = 32'h0AAE79E5;
  logic [15:0] sh [logic [7:0]];
  logic [7:0] cmds [6] = '{`CSWS_CMD_CFG, `CSWS_CMD_CUR, `CSWS_CMD_VOLT, `CSWS_CMD_INCUR, `CSWS_CMD_MAKER, `CSWS_CMD_PART};
  always #20 mclk_i = ~mclk_i;
  csws_slave #(.TIMEOUT_CYC(36'h0000000C8), .DEGLITCH_CYC(36'h000000028), .WD_P1_CYC(WD1), .WD_P2_CYC(WD2),
    .WD_P3_CYC(WD3), .PART_ID(PID), .MAKER_ID(MID)) dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .supply_ok_i(supply_ok), .adapter_sense_ok_i(adapter_ok), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .charger_configuration_o(cfg), .charge_current_limit_o(cur), .charge_voltage_limit_o(volt),
    .input_current_limit_o(incur), .watchdog_expired_o(wd_exp), .bus_timeout_o(tmo));
  csws_host_model h_u (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(host_pull));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic ok_cmd(input logic [7:0] c);
    foreach (cmds[i]) if (cmds[i] == c) return 1'b1;
    return 1'b0;
  endfunction
  function automatic logic [3:0] wr_exp(input logic [7:0] a, input logic [7:0] c);
    if (a != {`CSWS_SLAVE_ADDR, 1'b0} || !(supply_ok && adapter_ok)) return 4'hF;
    if (!ok_cmd(c)) return 4'h7;
    return (c >= `CSWS_CMD_MAKER) ? 4'h3 : 4'h0;
  endfunction
  function automatic int per(input logic [1:0] s);
    case (s)
      2'h1: return int'(WD1);
      2'h2: return int'(WD2);
      2'h3: return int'(WD3);
      default: return 1550;
    endcase
  endfunction
  function automatic logic [15:0] port_of(input logic [7:0] c);
    case (c)
      `CSWS_CMD_CFG: return cfg;
      `CSWS_CMD_CUR: return cur;
      `CSWS_CMD_VOLT: return volt;
      default: return incur;
    endcase
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d);
    logic [7:0] rx;
    logic [3:0] k;
    h_u.start();
    h_u.xfer(a, 1'b1, rx, k[3]);
    h_u.xfer(c, 1'b1, rx, k[2]);
    h_u.xfer(d[7:0], 1'b1, rx, k[1]);
    h_u.xfer(d[15:8], 1'b1, rx, k[0]);
    h_u.stop();
    check("write acks", {12'h000, k}, {12'h000, wr_exp(a, c)});
    if (wr_exp(a, c) == 4'h0) sh[c] = d;
  endtask
  task automatic rd_word(input logic [7:0] c, output logic [15:0] d, output logic [2:0] k);
    logic [7:0] rx;
    logic x;
    h_u.start();
    h_u.xfer({`CSWS_SLAVE_ADDR, 1'b0}, 1'b1, rx, k[2]);
    h_u.xfer(c, 1'b1, rx, k[1]);
    h_u.start();
    h_u.xfer({`CSWS_SLAVE_ADDR, `CSWS_DIR_READ}, 1'b1, rx, k[0]);
    h_u.xfer(8'hFF, 1'b0, d[7:0], x);
    h_u.xfer(8'hFF, 1'b1, d[15:8], x);
    h_u.stop();
  endtask
  task automatic chk_all();
    logic [15:0] d;
    logic [2:0] k;
    foreach (cmds[i]) begin
      rd_word(cmds[i], d, k);
      check("read acks", {13'h0000, k}, 16'h0000);
      check("read data", d, sh[cmds[i]]);
      if (i < 4) check("register port", port_of(cmds[i]), sh[cmds[i]]);
    end
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (tmo === 1'b1) n_tmo++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    logic [15:0] d;
    logic [2:0] k;
    logic [7:0] rx;
    logic ak;
    logic [31:0] r;
    logic [15:0] bad [5];
    int t;
    bad = '{16'h12FE, 16'h12FF, 16'h1220, 16'h1414, 16'h2414};
    sh[8'h12] = `CSWS_RST_CFG;
    sh[8'h14] = 16'h0000;
    sh[8'h15] = 16'h0000;
    sh[8'h3F] = 16'h0000;
    sh[8'hFE] = MID;
    sh[8'hFF] = PID;
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (1150) @(posedge mclk_i);
    check("watchdog early", {15'h0000, wd_exp}, 16'h0000);
    repeat (100) @(posedge mclk_i);
    check("watchdog default", {15'h0000, wd_exp}, 16'h0001);
    $display("test default watchdog done");
    chk_all();
    $display("test reset values done");
    for (int n = 0; n < 8; n++) begin
      r = rnd();
      h_u.half = 3 + int'(r[17:16]);
      d = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : r[15:0];
      wr_chk(8'h12, cmds[r[21:20]], d);
    end
    h_u.half = 3;
    chk_all();
    $display("test random words done");
    foreach (bad[i]) begin
      r = rnd();
      wr_chk(bad[i][15:8], bad[i][7:0], r[15:0]);
    end
    rd_word(8'h20, d, k);
    check("unknown read acks", {13'h0000, k}, 16'h0003);
    h_u.start();
    h_u.xfer(8'h13, 1'b1, rx, ak);
    h_u.stop();
    check("read without command", {15'h0000, ak}, 16'h0001);
    h_u.start();
    h_u.xfer(8'h12, 1'b1, rx, ak);
    h_u.xfer(8'h14, 1'b1, rx, ak);
    h_u.xfer(8'h5A, 1'b1, rx, ak);
    h_u.stop();
    for (int n = 0; n < 2; n++) begin
      @(posedge mclk_i);
      {supply_ok, adapter_ok} <= n ? 2'b10 : 2'b01;
      r = rnd();
      wr_chk(8'h12, 8'h14, r[15:0]);
    end
    @(posedge mclk_i);
    {supply_ok, adapter_ok} <= 2'b11;
    chk_all();
    $display("test refusals done");
    t = n_tmo;
    h_u.start();
    h_u.xfer(8'h12, 1'b1, rx, ak);
    repeat (250) @(posedge mclk_i);
    check("timeout pulses", 16'(n_tmo - t), 16'h0001);
    check("released data", {15'h0000, sda_oe}, 16'h0000);
    h_u.stop();
    chk_all();
    $display("test bus timeout done");
    for (int n = 1; n < 5; n++) begin
      d = sh[8'h12];
      d[14:13] = 2'(n);
      wr_chk(8'h12, 8'h12, d);
      if (n > 1) check("restart deglitch", {15'h0000, wd_exp}, 16'h0001);
      repeat (per(d[14:13]) - 50) @(posedge mclk_i);
      check("watchdog before period", {15'h0000, wd_exp}, 16'h0000);
      if (n < 4) begin
        repeat (100) @(posedge mclk_i);
        check("watchdog after period", {15'h0000, wd_exp}, 16'h0001);
      end
    end
    $display("test watchdog periods done");
    finish_test();
  end
endmodule

/* File: test/csws_host_model.sv */
// Two-wire bus host model: opens, moves bytes and closes transfers.
`timescale 1ns/1ps
module csws_host_model (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  int half = 3;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Serves as both first and repeated start; the clock is left low.
  task automatic start();
    wt(1);
    sda_pull_o <= 1'b0;
    wt(half);
    scl_o <= 1'b1;
    wt(half);
    sda_pull_o <= 1'b1;
    wt(half);
    scl_o <= 1'b0;
    wt(half);
  endtask
  task automatic stop();
    wt(1);
    sda_pull_o <= 1'b1;
    wt(half);
    scl_o <= 1'b1;
    wt(half);
    sda_pull_o <= 1'b0;
    wt(half);
  endtask
  task automatic bit_io(input logic b, output logic s);
    wt(1);
    sda_pull_o <= ~b;
    wt(half);
    scl_o <= 1'b1;
    wt(half);
    s = sda_i;
    scl_o <= 1'b0;
  endtask
  // Sends tx (all ones to listen), answers with ack_bit in the ninth clock.
  task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ack_bit, ack);
  endtask
endmodule

/* File: test/csws_slave_sva.sv */
// Port checker of the charger two-wire word slave, bound to its top module.
`timescale 1ns/1ps
`include "csws_defines.vh"
module csws_slave_sva #(
  parameter [35:0] TIMEOUT_CYC = `CSWS_TIMEOUT_MS * `CSWS_CLK_KHZ,
  parameter [35:0] DEGLITCH_CYC = `CSWS_DEGLITCH_MS * `CSWS_CLK_KHZ,
  parameter [35:0] WD_P1_CYC = `CSWS_WD_P1_MS * `CSWS_CLK_KHZ
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire supply_ok_i,
  input wire adapter_sense_ok_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire [15:0] charger_configuration_o,
  input wire [15:0] charge_current_limit_o,
  input wire [15:0] charge_voltage_limit_o,
  input wire [15:0] input_current_limit_o,
  input wire watchdog_expired_o,
  input wire bus_timeout_o
);
  wire en = supply_ok_i & adapter_sense_ok_i;
  wire [63:0] regs = {charger_configuration_o, charge_current_limit_o, charge_voltage_limit_o, input_current_limit_o};
  reg [63:0] regs_reg;
  reg [35:0] low_reg;
  reg [35:0] since_wr_reg;
  // The write-age counter saturates so that a long quiet stretch cannot wrap into a false match.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regs_reg <= {`CSWS_RST_CFG, 48'h000000000000};
      low_reg <= 36'h000000000;
      since_wr_reg <= 36'hFFFFFFFFF;
    end else begin
      regs_reg <= regs;
      low_reg <= scl_i ? 36'h000000000 : low_reg + 36'h000000001;
      if (regs != regs_reg) since_wr_reg <= 36'h000000000;
      else if (since_wr_reg != 36'hFFFFFFFFF) since_wr_reg <= since_wr_reg + 36'h000000001;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ack_low; sda_oe_o |-> !sda_o; endproperty
  a_ack_low: assert property (p_ack_low) else $error("data driven high");
  property p_off_release; !en |-> ##2 !sda_oe_o; endproperty
  a_off_release: assert property (p_off_release) else $error("data held while disabled");
  property p_change_low; $changed(sda_oe_o) && en && $past(en) |-> !scl_i && !$past(scl_i); endproperty
  a_change_low: assert property (p_change_low) else $error("data changed with clock high");
  property p_no_start; scl_i && $past(scl_i) |-> !$rose(sda_oe_o); endproperty
  a_no_start: assert property (p_no_start) else $error("device formed a start");
  property p_tmo_cause; bus_timeout_o |-> low_reg >= TIMEOUT_CYC - 36'h2 && low_reg <= TIMEOUT_CYC + 36'h3; endproperty
  a_tmo_cause: assert property (p_tmo_cause) else $error("timeout at wrong low time");
  property p_tmo_release; bus_timeout_o |=> !bus_timeout_o ##1 !sda_oe_o [*3]; endproperty
  a_tmo_release: assert property (p_tmo_release) else $error("bus not released after timeout");
  property p_commit_ack; $changed(regs) |-> $rose(sda_oe_o) && !scl_i; endproperty
  a_commit_ack: assert property (p_commit_ack) else $error("register changed outside ack");
  property p_restart_deglitch; $fell(watchdog_expired_o) |-> since_wr_reg >= DEGLITCH_CYC - 36'h2; endproperty
  a_restart_deglitch: assert property (p_restart_deglitch) else $error("restart not deglitched");
  // A write may land just before an expiry that its own restart has not yet cancelled.
  property p_expire_min;
    $rose(watchdog_expired_o) |-> since_wr_reg >= WD_P1_CYC || since_wr_reg <= DEGLITCH_CYC + 36'h2;
  endproperty
  a_expire_min: assert property (p_expire_min) else $error("watchdog expired early");
  c_commit: cover property ($changed(regs));
  c_tmo: cover property (bus_timeout_o);
  c_expire: cover property ($rose(watchdog_expired_o));
  c_clear: cover property ($fell(watchdog_expired_o));
endmodule

bind csws_slave csws_slave_sva #(.TIMEOUT_CYC(TIMEOUT_CYC), .DEGLITCH_CYC(DEGLITCH_CYC), .WD_P1_CYC(WD_P1_CYC)) chk_u (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .supply_ok_i(supply_ok_i), .adapter_sense_ok_i(adapter_sense_ok_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .charger_configuration_o(charger_configuration_o), .charge_current_limit_o(charge_current_limit_o),
  .charge_voltage_limit_o(charge_voltage_limit_o), .input_current_limit_o(input_current_limit_o),
  .watchdog_expired_o(watchdog_expired_o), .bus_timeout_o(bus_timeout_o));
